/* File: lfcb_top.sv */
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "lfcb_map.svh"

module lfcb_top #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // coefficients to the loop filter, high margin 0..3, normal margin 4..7
  output logic [`LFCB_NUM_COEF-1:0][15:0] coef_lin,
  output logic [`LFCB_NUM_COEF-1:0][7:0] coef_exp
);

  localparam int AW2 = ADDR_W - 2;

  // the index window 0x317..0x32e needs byte address bit 11
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_addr_check
    $error("lfcb_top: ADDR_W must lie in 12..32");
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [7:0] bank_reg [0:`LFCB_NUM_REGS-1];
  logic aw_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic awready_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_write;
  logic wr_hit;
  lfcb_pkg::lfcb_slot_type wr_slot;
  logic rd_hit;
  lfcb_pkg::lfcb_slot_type rd_slot;
  logic [7:0] rd_byte;

  function automatic logic [AW2-1:0] word_index(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  // low two address bits are ignored: every register is one aligned word
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [AW2-1:0] wi;
    wi = word_index(a);
    return (wi >= AW2'(`LFCB_IDX_FIRST)) && (wi <= AW2'(`LFCB_IDX_LAST));
  endfunction

  function automatic lfcb_pkg::lfcb_slot_type addr_slot(input logic [ADDR_W-1:0] a);
    logic [AW2-1:0] wi;
    wi = word_index(a) - AW2'(`LFCB_IDX_FIRST);
    return 5'(wi);
  endfunction

  function automatic lfcb_pkg::lfcb_field_type field_of(input lfcb_pkg::lfcb_slot_type s);
    return lfcb_pkg::lfcb_field_type'(2'(s % `LFCB_REGS_PER_COEF));
  endfunction

  function automatic logic [2:0] coef_of(input lfcb_pkg::lfcb_slot_type s);
    return 3'(s / `LFCB_REGS_PER_COEF);
  endfunction

  // bank slot of one field of coefficient k
  function automatic int slot_of(input int k, input lfcb_pkg::lfcb_field_type f);
    return k * `LFCB_REGS_PER_COEF + int'(f);
  endfunction

  // reserved exponent bit is forced to zero on the way in
  function automatic logic [7:0] store_value(input lfcb_pkg::lfcb_slot_type s, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (field_of(s) == lfcb_pkg::LFCB_EXP) begin
      v[`LFCB_EXP_RSVD_BIT] = 1'b0;
    end
    return v;
  endfunction

  // 7-bit two's complement exponent widened with its sign
  function automatic lfcb_pkg::lfcb_exp_type exp_value(input logic [7:0] b);
    return {b[`LFCB_EXP_SIGN_BIT], b[`LFCB_EXP_SIGN_BIT:0]};
  endfunction

  assign wr_hit = addr_hit(aw_addr_reg);
  assign wr_slot = addr_slot(aw_addr_reg);
  assign rd_hit = addr_hit(araddr);
  assign rd_slot = addr_slot(araddr);
  assign rd_byte = rd_hit ? bank_reg[rd_slot] : 8'h00;
  // one write at a time: the response must drain before the next commit
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

  // write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      awready_reg <= 1'b0;
    end else if (awvalid && awready_reg) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= awaddr;
      awready_reg <= 1'b0;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end else if (bvalid_reg && bready) begin
      awready_reg <= 1'b1;
    end else begin
      awready_reg <= !aw_held_reg && !bvalid_reg;
    end
  end

  // write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      wready_reg <= 1'b0;
    end else if (wvalid && wready_reg) begin
      w_held_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
      wready_reg <= 1'b0;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end else if (bvalid_reg && bready) begin
      wready_reg <= 1'b1;
    end else begin
      wready_reg <= !w_held_reg && !bvalid_reg;
    end
  end

  // write response; an unmapped address is refused, not silently dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `LFCB_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? `LFCB_RESP_OKAY : `LFCB_RESP_DECERR;
    end else if (bvalid_reg && bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // coefficient bank; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `LFCB_NUM_REGS; i++) begin
        bank_reg[i] <= (i == 0) ? `LFCB_RST_ALPHA_LO : `LFCB_RST_DEFAULT;
      end
    end else if (do_write && wr_hit && w_strb_reg[0]) begin
      bank_reg[wr_slot] <= store_value(wr_slot, w_data_reg[7:0]);
    end
  end

  // read channel; a read in the same cycle as a commit sees the old byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `LFCB_RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= rd_hit ? `LFCB_RESP_OKAY : `LFCB_RESP_DECERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end else begin
      arready_reg <= !rvalid_reg;
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // value = coef_lin / 2**16 * 2**coef_exp; the filter does the scaling
  for (genvar k = 0; k < `LFCB_NUM_COEF; k++) begin : g_coef
    assign coef_lin[k] = {bank_reg[slot_of(k, lfcb_pkg::LFCB_LIN_HI)],
      bank_reg[slot_of(k, lfcb_pkg::LFCB_LIN_LO)]};
    assign coef_exp[k] = exp_value(bank_reg[slot_of(k, lfcb_pkg::LFCB_EXP)]);
  end

  // helper logic for the checks below
  logic exp_rsvd_any;
  always_comb begin
    exp_rsvd_any = 1'b0;
    for (int k = 0; k < `LFCB_NUM_COEF; k++) begin
      exp_rsvd_any = exp_rsvd_any | bank_reg[slot_of(k, lfcb_pkg::LFCB_EXP)][`LFCB_EXP_RSVD_BIT];
    end
  end

  sequence write_commit;
    do_write && wr_hit && w_strb_reg[0];
  endsequence

  sequence read_taken;
    arvalid && arready_reg;
  endsequence

  sequence read_at(logic [9:0] idx);
    read_taken ##0 (word_index(araddr) == AW2'(idx));
  endsequence

  sequence exp_read;
    read_taken ##0 (rd_hit && field_of(rd_slot) == lfcb_pkg::LFCB_EXP);
  endsequence

  rst_alpha_a: assert property (
    $rose(aresetn) |-> (coef_lin[0][7:0] == `LFCB_RST_ALPHA_LO) && (coef_lin[0][15:8] == `LFCB_RST_DEFAULT))
    else $error("alpha low byte not at its reset value");

  lin_low_a: assert property (
    write_commit ##0 (field_of(wr_slot) == lfcb_pkg::LFCB_LIN_LO)
    |=> coef_lin[$past(coef_of(wr_slot))][7:0] == $past(w_data_reg[7:0]))
    else $error("linear low byte write lost");

  lin_high_a: assert property (
    write_commit ##0 (field_of(wr_slot) == lfcb_pkg::LFCB_LIN_HI)
    |=> coef_lin[$past(coef_of(wr_slot))][15:8] == $past(w_data_reg[7:0]))
    else $error("linear high byte write lost");

  exp_store_a: assert property (
    write_commit ##0 (field_of(wr_slot) == lfcb_pkg::LFCB_EXP)
    |=> bank_reg[$past(wr_slot)] == {1'b0, $past(w_data_reg[6:0])})
    else $error("exponent byte stored wrongly");

  exp_sign_a: assert property (
    write_commit ##0 (field_of(wr_slot) == lfcb_pkg::LFCB_EXP)
    |=> $signed(coef_exp[$past(coef_of(wr_slot))]) == $signed($past(w_data_reg[6:0])))
    else $error("exponent sign not carried");

  rsvd_zero_a: assert property (
    !exp_rsvd_any)
    else $error("reserved exponent bit set");

  rsvd_read_a: assert property (
    exp_read |=> rvalid_reg && rdata_reg[7:0] == {1'b0, $past(coef_exp[coef_of(rd_slot)][`LFCB_EXP_SIGN_BIT:0])})
    else $error("exponent read back wrongly");

  high_map_a: assert property (
    read_at(`LFCB_IDX_HIGH_DELTA_EXP)
    |=> rvalid_reg && rresp_reg == `LFCB_RESP_OKAY && rdata_reg[6:0] == $past(coef_exp[3][6:0]))
    else $error("high margin delta exponent misplaced");

  norm_map_a: assert property (
    read_at(`LFCB_IDX_NORM_ALPHA_LIN_HI)
    |=> rvalid_reg && rresp_reg == `LFCB_RESP_OKAY && rdata_reg == {24'h00_0000, $past(coef_lin[4][15:8])})
    else $error("normal margin alpha high byte misplaced");

  unmapped_a: assert property (
    read_taken ##0 !rd_hit |=> rvalid_reg && rresp_reg == `LFCB_RESP_DECERR && rdata_reg == 32'h0000_0000)
    else $error("unmapped read not refused");

  bresp_hold_a: assert property (
    do_write |=> bvalid_reg ##0 (bvalid_reg && !bready) [*1] |=> bvalid_reg && $stable(bresp_reg))
    else $error("write response dropped early");

  write_okay_a: assert property (
    do_write ##0 wr_hit |=> bvalid_reg && bresp_reg == `LFCB_RESP_OKAY)
    else $error("mapped write not acknowledged");

  unmapped_wr_a: assert property (
    do_write ##0 !wr_hit |=> bvalid_reg && bresp_reg == `LFCB_RESP_DECERR && $stable(coef_lin) && $stable(coef_exp))
    else $error("unmapped write not refused");

  strobe_off_a: assert property (
    do_write ##0 !w_strb_reg[0] |=> bvalid_reg && $stable(coef_lin) && $stable(coef_exp))
    else $error("write without lane 0 strobe changed a byte");

  rst_rest_a: assert property (
    $rose(aresetn) |-> coef_exp == '0 && coef_lin[`LFCB_NUM_COEF-1:1] == '0 && !bvalid_reg && !rvalid_reg)
    else $error("bank or answers not cleared by reset");

  read_answer_a: assert property (
    read_taken |=> rvalid_reg && !arready_reg)
    else $error("read answer late");

  rresp_hold_a: assert property (
    rvalid_reg && !rready |=> rvalid_reg && $stable(rdata_reg) && $stable(rresp_reg))
    else $error("read answer dropped early");

  one_write_a: assert property (
    bvalid_reg |-> !awready_reg && !wready_reg)
    else $error("new write accepted before the response drained");

  wr_ready_back_a: assert property (
    bvalid_reg && bready |=> awready_reg && wready_reg && !bvalid_reg)
    else $error("write channels not reopened");

  rd_ready_back_a: assert property (
    rvalid_reg && rready |=> arready_reg && !rvalid_reg)
    else $error("read channel not reopened");

endmodule
`default_nettype wire

/* File: lfcb_map.svh */
`ifndef LFCB_MAP_SVH
`define LFCB_MAP_SVH

// register indices; byte address is four times the index
`define LFCB_IDX_HIGH_ALPHA_LIN_LO 10'h317
`define LFCB_IDX_HIGH_ALPHA_LIN_HI 10'h318
`define LFCB_IDX_HIGH_ALPHA_EXP 10'h319
`define LFCB_IDX_HIGH_BETA_LIN_LO 10'h31a
`define LFCB_IDX_HIGH_BETA_LIN_HI 10'h31b
`define LFCB_IDX_HIGH_BETA_EXP 10'h31c
`define LFCB_IDX_HIGH_GAMMA_LIN_LO 10'h31d
`define LFCB_IDX_HIGH_GAMMA_LIN_HI 10'h31e
`define LFCB_IDX_HIGH_GAMMA_EXP 10'h31f
`define LFCB_IDX_HIGH_DELTA_LIN_LO 10'h320
`define LFCB_IDX_HIGH_DELTA_LIN_HI 10'h321
`define LFCB_IDX_HIGH_DELTA_EXP 10'h322
`define LFCB_IDX_NORM_ALPHA_LIN_LO 10'h323
`define LFCB_IDX_NORM_ALPHA_LIN_HI 10'h324
`define LFCB_IDX_NORM_ALPHA_EXP 10'h325
`define LFCB_IDX_NORM_BETA_LIN_LO 10'h326
`define LFCB_IDX_NORM_BETA_LIN_HI 10'h327
`define LFCB_IDX_NORM_BETA_EXP 10'h328
`define LFCB_IDX_NORM_GAMMA_LIN_LO 10'h329
`define LFCB_IDX_NORM_GAMMA_LIN_HI 10'h32a
`define LFCB_IDX_NORM_GAMMA_EXP 10'h32b
`define LFCB_IDX_NORM_DELTA_LIN_LO 10'h32c
`define LFCB_IDX_NORM_DELTA_LIN_HI 10'h32d
`define LFCB_IDX_NORM_DELTA_EXP 10'h32e

// bank shape
`define LFCB_IDX_FIRST `LFCB_IDX_HIGH_ALPHA_LIN_LO
`define LFCB_IDX_LAST `LFCB_IDX_NORM_DELTA_EXP
`define LFCB_NUM_REGS 24
`define LFCB_NUM_COEF 8
`define LFCB_REGS_PER_COEF 5'h03

// field layout and reset values
`define LFCB_EXP_RSVD_BIT 7
`define LFCB_EXP_SIGN_BIT 6
`define LFCB_RST_ALPHA_LO 8'h8c
`define LFCB_RST_DEFAULT 8'h00

// bus answers
`define LFCB_RESP_OKAY 2'h0
`define LFCB_RESP_DECERR 2'h3

`endif

/* File: lfcb_pkg.sv */
`default_nettype none
package lfcb_pkg;

  // position of a byte inside one coefficient
  typedef enum logic [1:0] {
    LFCB_LIN_LO = 2'h0,
    LFCB_LIN_HI = 2'h1,
    LFCB_EXP = 2'h2
  } lfcb_field_type;

  typedef logic signed [7:0] lfcb_exp_type;
  typedef logic [4:0] lfcb_slot_type;

endpackage
`default_nettype wire

/* File: tb_loop_filter_coeff_bank.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_loop_filter_coeff_bank;
  localparam int AW = 12;
  localparam int BASE = 32'h317;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic [AW-1:0] awaddr = '0;
  logic [AW-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic bready = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0][15:0] coef_lin;
  logic [7:0][7:0] coef_exp;
  int mismatches = 0;
  int compares = 0;
  // byte model of the bank, index 0 is the high margin alpha linear low byte
  int mem [24];

  // answers are taken after a random pause, so the bank must hold them standing
  lfcb_top #(.ADDR_W(AW)) i_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .coef_lin(coef_lin),
    .coef_exp(coef_exp));

  always #12.5 aclk = ~aclk;

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // late delays the data one cycle behind the address; otherwise address and data are offered together
  task automatic wr(input int idx, input logic [7:0] d, input logic s, input bit late, output logic [1:0] r);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    awaddr <= AW'(idx * 4);
    wdata <= {24'($urandom), d};
    wstrb <= {3'($urandom), s};
    awvalid <= 1'b1;
    wvalid <= !late;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end else if (!wd) begin
        wvalid <= 1'b1;
      end
    end
    repeat ($urandom_range(2)) @(posedge aclk);
    bready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask

  task automatic rd(input int idx, output logic [31:0] d, output logic [1:0] r);
    araddr <= AW'(idx * 4);
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge aclk);
    rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  task automatic chk_all();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 24; i++) begin
      rd(BASE + i, d, r);
      chk(d, 32'(mem[i]));
      chk(32'(r), 32'h0);
    end
    for (int k = 0; k < 8; k++) begin
      chk(32'(coef_lin[k]), 32'(mem[3*k+1] * 256 + mem[3*k]));
      chk(32'(coef_exp[k]), 32'({mem[3*k+2][6], mem[3*k+2][6:0]}));
    end
  endtask

  task automatic do_reset(input int n);
    aresetn <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (mem[i]) mem[i] = (i == 0) ? 32'h8c : 32'h0;
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] v;
    void'($urandom(68));
    do_reset(10);
    chk_all();
    for (int i = 0; i < 24; i++) begin
      v = 8'($urandom);
      // the reserved exponent bit is always offered set, so a leak shows at once
      if (i % 3 == 2) v[7] = 1'b1;
      wr(BASE + i, v, 1'b1, i[0], r);
      chk(32'(r), 32'h0);
      mem[i] = (i % 3 == 2) ? (v & 8'h7f) : v;
    end
    chk_all();
    wr(BASE, ~8'(mem[0]), 1'b0, 1'b0, r);
    chk(32'(r), 32'h0);
    for (int j = -1; j < 25; j += 25) begin
      wr(BASE + j, 8'h5a, 1'b1, 1'b0, r);
      chk(32'(r), 32'h3);
      rd(BASE + j, d, r);
      chk(d, 32'h0);
      chk(32'(r), 32'h3);
    end
    chk_all();
    do_reset(2);
    chk_all();
    give_verdict();
  end

  // about 400 cycles are needed with the random pauses; the margin covers a slow answer path
  initial begin
    #(25 * 20000);
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
